// file: verilog/cidop_regs.vh
// constants for the clear/invert/decrement execute block
// Functional notes
// - accumulator clear opcode zeroes the accumulator and sets zero flag, one cycle.
// - watchdog clear opcode pulses wdt_clr_o for one cycle and sets expiry and sleep flags.
// - invert opcode writes bitwise inverse of file register, updates zero flag.
// - destination bit 0 writes accumulator, 1 writes the addressed file register.
// - decrement opcode subtracts one, zero flag set on zero result, else cleared.
// - decrement-skip opcode writes decremented value, leaves zero, expiry and sleep flags unchanged.
// - decrement-skip zero result discards next instruction as NOP, two cycles.
// - file address is low seven opcode bits, destination bit just above.
`ifndef CIDOP_REGS_VH
`define CIDOP_REGS_VH

`define CIDOP_OP_ACC_CLR   14'h0140
`define CIDOP_OP_WDT_CLR   14'h1E04
`define CIDOP_OP_INV       6'h09
`define CIDOP_OP_DEC       6'h03
`define CIDOP_OP_DEC_SKIP  6'h0B

`define CIDOP_DST_BIT      7
`define CIDOP_ADDR_MSB     6

`define CIDOP_ADDR_CTRL    4'h0
`define CIDOP_ADDR_STATUS  4'h4
`define CIDOP_ADDR_ACC     4'h8

`define CIDOP_CTRL_EN_BIT  0
`define CIDOP_CTRL_RST     1'b1
`define CIDOP_ACC_RST      8'h00
`define CIDOP_ZERO_RST     1'b0
`define CIDOP_EXP_RST      1'b1
`define CIDOP_SLEEP_RST    1'b1

`define CIDOP_ST_ZERO      0
`define CIDOP_ST_EXP       1
`define CIDOP_ST_SLEEP     2
`define CIDOP_ST_SKIP      3

`endif

// file: verilog/cidop_exec.v
// execute stage for clear, invert and decrement instructions with apb view
//
// The implementer's own choices: the placing of the registers and register access over APB.
`include "cidop_regs.vh"
`default_nettype none

module cidop_exec (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_i,
  // instruction stream, one instruction cycle per valid
  input  wire [13:0] instr_i,
  input  wire        instr_valid_i,
  input  wire [7:0]  freg_rdata_i,
  // file register write port
  output wire [6:0]  freg_waddr_o,
  output wire [7:0]  freg_wdata_o,
  output wire        freg_we_o,
  // core state
  output wire [7:0]  acc_o,
  output wire        zero_o,
  output wire        expiry_o,
  output wire        sleep_o,
  output wire        wdt_clr_o,
  output wire        skip_o,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [3:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o
);

  reg [6:0]  waddr_q;
  reg [7:0]  wdata_q;
  reg        we_q;
  reg [7:0]  acc_q;
  reg        zero_q;
  reg        exp_q;
  reg        sleep_q;
  reg        wdt_clr_q;
  reg        skip_q;
  reg        en_q;
  reg [31:0] prdata_q;
  reg        pready_q;
  reg        pslverr_q;

  // status word laid out by the field positions of the header
  reg [31:0] status_rd;
  always @* begin
    status_rd                  = 32'h0000_0000;
    status_rd[`CIDOP_ST_ZERO]  = zero_q;
    status_rd[`CIDOP_ST_EXP]   = exp_q;
    status_rd[`CIDOP_ST_SLEEP] = sleep_q;
    status_rd[`CIDOP_ST_SKIP]  = skip_q;
  end

  // destination and flag decisions for one instruction
  reg [7:0]  res_d;
  reg        wr_res_d;
  reg        upd_zero_d;
  reg        skip_d;

  // file address and destination bit sit in the low opcode bits
  wire [5:0] op_hi   = instr_i[13:8];
  wire       dst_f   = instr_i[`CIDOP_DST_BIT];
  wire [6:0] f_addr  = instr_i[`CIDOP_ADDR_MSB:0];
  wire       run     = instr_valid_i & en_q;
  // decrement wraps 00 to FF, the zero flag then reads clear
  wire [7:0] dec_val = freg_rdata_i - 8'h01;
  // the two operand-less opcodes are matched on the whole word,
  // so neighbouring encodings with the same high bits do nothing
  wire       op_acc_clr = (instr_i == `CIDOP_OP_ACC_CLR);
  wire       op_wdt_clr = (instr_i == `CIDOP_OP_WDT_CLR);

  // zero test shared by the flag update and the skip decision

  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == 8'h00);
    end
  endfunction

  // result, destination and flag choice for the operand opcodes
  always @* begin
    res_d      = 8'h00;
    wr_res_d   = 1'b0;
    upd_zero_d = 1'b0;
    skip_d     = 1'b0;
    case (op_hi)
      `CIDOP_OP_INV: begin
        res_d      = ~freg_rdata_i;
        wr_res_d   = 1'b1;
        upd_zero_d = 1'b1;
      end
      `CIDOP_OP_DEC: begin
        res_d      = dec_val;
        wr_res_d   = 1'b1;
        upd_zero_d = 1'b1;
      end
      `CIDOP_OP_DEC_SKIP: begin
        res_d      = dec_val;
        wr_res_d   = 1'b1;
        skip_d     = is_zero(dec_val);
      end
      // other opcodes, the two whole-word ones included, write nothing
      default: begin
        wr_res_d   = 1'b0;
      end
    endcase
  end

  // instruction execution; a pending skip swallows the next taken
  // slot whatever it holds, so two skips can never chain
  // with enable low nothing is taken, a pending skip waits too
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      waddr_q   <= 7'h00;
      wdata_q   <= 8'h00;
      we_q      <= 1'b0;
      acc_q     <= `CIDOP_ACC_RST;
      zero_q    <= `CIDOP_ZERO_RST;
      exp_q     <= `CIDOP_EXP_RST;
      sleep_q   <= `CIDOP_SLEEP_RST;
      wdt_clr_q <= 1'b0;
      skip_q    <= 1'b0;
    end else begin
      // the write strobe and the watchdog clear stand one cycle only
      we_q      <= 1'b0;
      wdt_clr_q <= 1'b0;
      if (run) begin
        if (skip_q) begin
          // discarded slot behaves as nop, second cycle of the skip
          skip_q <= 1'b0;
        end else begin
          skip_q <= skip_d;
          if (op_acc_clr) begin
            acc_q  <= 8'h00;
            zero_q <= 1'b1;
          end else if (op_wdt_clr) begin
            wdt_clr_q <= 1'b1;
            exp_q     <= 1'b1;
            sleep_q   <= 1'b1;
          end else if (wr_res_d) begin
            if (dst_f) begin
              waddr_q <= f_addr;
              wdata_q <= res_d;
              we_q    <= 1'b1;
            end else begin
              acc_q <= res_d;
            end
            if (upd_zero_d) begin
              zero_q <= is_zero(res_d);
            end
          end
        end
      end
    end
  end

  // apb slave, one wait state so every answer comes from a flop;
  // a write lands in the access cycle, on the same edge that raises pready
  // only the enable bit is writable, writes to status and acc drop silently
  wire acc_phase = psel_i & penable_i & ~pready_q;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      // enable comes out of reset set so the core runs at once
      en_q      <= `CIDOP_CTRL_RST;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc_phase;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (acc_phase) begin
        case (paddr_i)
          `CIDOP_ADDR_CTRL: begin
            if (pwrite_i) begin
              en_q <= pwdata_i[`CIDOP_CTRL_EN_BIT];
            end else begin
              prdata_q <= {31'h0000_0000, en_q};
            end
          end
          // read-only words: a write is accepted and dropped
          `CIDOP_ADDR_STATUS: begin
            if (!pwrite_i) begin
              prdata_q <= status_rd;
            end
          end
          `CIDOP_ADDR_ACC: begin
            if (!pwrite_i) begin
              prdata_q <= {24'h00_0000, acc_q};
            end
          end
          // unmapped offsets answer with an error and zero data
          default: begin
            pslverr_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // every output comes straight from its flop
  assign freg_waddr_o = waddr_q;
  assign freg_wdata_o = wdata_q;
  assign freg_we_o    = we_q;
  assign acc_o        = acc_q;
  assign zero_o       = zero_q;
  assign expiry_o     = exp_q;
  assign sleep_o      = sleep_q;
  assign wdt_clr_o    = wdt_clr_q;
  assign skip_o       = skip_q;
  assign prdata_o     = prdata_q;
  assign pready_o     = pready_q;
  assign pslverr_o    = pslverr_q;

endmodule

`default_nettype wire

// file: verification/cidop_exec_asserts.sv
// assertions for the execute block
`default_nettype none
module cidop_exec_asserts (
  // clock, reset, instruction side
  input wire        clk_sys_i,
  input wire        rst_i,
  input wire [13:0] instr_i,
  input wire        instr_valid_i,
  input wire [7:0]  freg_rdata_i,
  // results
  input wire        freg_we_o,
  input wire [6:0]  freg_waddr_o,
  input wire [7:0]  freg_wdata_o,
  input wire [7:0]  acc_o,
  input wire        zero_o,
  input wire        expiry_o,
  input wire        sleep_o,
  input wire        wdt_clr_o,
  input wire        skip_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire       t = instr_valid_i & ~skip_o;
  wire [5:0] o = instr_i[13:8];
  wire [7:0] m = freg_rdata_i - 8'h01;
  a_acc_clear:
    assert property (t && instr_i == 14'h0140 |=> acc_o == 8'h00 && zero_o)
    else $error("acc clear");
  a_wdt_pulse:
    assert property (t && instr_i == 14'h1E04 |=> wdt_clr_o) else $error("wdt");
  a_wdt_flags:
    assert property (t && instr_i == 14'h1E04 |=> expiry_o && sleep_o)
    else $error("wdt flags");
  a_invert_acc:
    assert property (t && o == 6'h09 && !instr_i[7] |=>
      acc_o == ~$past(freg_rdata_i) && zero_o == (acc_o == 8'h00))
    else $error("invert");
  a_file_dest:
    assert property (t && o inside {6'h09, 6'h03, 6'h0B} && instr_i[7] |=>
      freg_we_o && freg_waddr_o == $past(instr_i[6:0])) else $error("dest");
  a_dec_value:
    assert property (t && o == 6'h03 |=> zero_o == ($past(m) == 8'h00) &&
      (freg_we_o ? freg_wdata_o : acc_o) == $past(m)) else $error("dec");
  a_skip_flags:
    assert property (t && o == 6'h0B |=> $stable(zero_o) && $stable(expiry_o))
    else $error("skip flags");
  a_skip_nop:
    assert property (skip_o && instr_valid_i |=> !skip_o && !freg_we_o &&
      !wdt_clr_o && $stable(acc_o) && $stable(zero_o))
    else $error("skip nop");
  c_skip: cover property (skip_o && instr_valid_i);
  c_wdt: cover property (wdt_clr_o);
  c_wzero: cover property (freg_we_o && freg_wdata_o == 8'h00);
endmodule
bind cidop_exec cidop_exec_asserts u_chk (.*);
`default_nettype wire

// file: verification/cidop_exec_test.sv
// random bench for the execute block
`default_nettype none
module cidop_exec_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_i, rst_i, instr_valid_i, psel_i, penable_i, pwrite_i;
  logic        freg_we_o, zero_o, expiry_o, sleep_o, wdt_clr_o, skip_o;
  logic        pready_o, pslverr_o, ez, sk, we, wd, pe;
  logic [13:0] instr_i;
  logic [3:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, s;
  logic [6:0]  freg_waddr_o;
  logic [7:0]  freg_wdata_o, acc_o, ea, r, mem [128];
  logic [13:0] ops [5] = '{14'h0140, 14'h1E04, 14'h0900, 14'h0300, 14'h0B00};
  int          n_mismatch, compares, i, k;
  wire  [7:0]  freg_rdata_i = mem[instr_i[6:0]];
  cidop_exec u_cidop_exec (.*);
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t %h %h", $time, g, e);
    end
  endtask
  task summarize();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task apb(input logic w, input logic [3:0] a);
    @(posedge clk_sys_i);
    {psel_i, pwrite_i, paddr_i} <= {1'b1, w, a};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    for (i = 0; i < 9 && pready_o !== 1'b1; i++) @(posedge clk_sys_i);
    {rd, pe} = {prdata_o, pslverr_o};
    {psel_i, penable_i} <= 2'h0;
    if (i == 9) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task step(input logic [13:0] n);
    @(posedge clk_sys_i);
    {instr_i, instr_valid_i} <= {n, 1'b1};
    {r, we, wd} = {mem[n[6:0]], 2'h0};
    if (sk) sk = 1'b0;
    else if (n == 14'h0140) {ea, ez} = 9'h001;
    else if (n == 14'h1E04) wd = 1'b1;
    else if (n[13:8] inside {6'h09, 6'h03, 6'h0B}) begin
      r = n[9] ? r - 8'h01 : ~r;
      if (n[11] & n[9]) sk = r == 8'h00;
      else ez = r == 8'h00;
      if (n[7]) we = 1'b1;
      else ea = r;
    end
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b0;
    #1;
    chk({acc_o, zero_o, skip_o, freg_we_o, wdt_clr_o}, {ea, ez, sk, we, wd});
    chk({expiry_o, sleep_o}, 32'h3);
    if (we) chk({freg_waddr_o, freg_wdata_o}, {n[6:0], r});
    if (we) mem[n[6:0]] = r;
  endtask
  initial begin
    {rst_i, instr_valid_i, psel_i, penable_i, pwrite_i} = 5'h10;
    {instr_i, paddr_i, pwdata_i} = {18'h0, 32'hFF};
    {ea, ez, sk, s} = {10'h0, 32'h2798};
    foreach (mem[j]) mem[j] = 8'(rnd());
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    apb(1'b0, 4'h4);
    chk(rd, 32'h6);
    mem[127] = 8'h01;
    step(14'h0BFF);
    step(14'h0900);
    repeat (400) begin
      k = rnd() % 5;
      if (s[10:9] == 2'h0) mem[s[6:0]] = {7'h0, s[11]};
      step(ops[k] | (k > 1 ? {6'h0, s[7:0]} : 14'h0));
      if (s[15:13] == 3'h0) begin
        apb(s[16], {s[18:17], 2'h0});
        chk(pe, s[18:17] == 2'h3);
        if (!s[16]) chk(rd, s[18:17] == 2'h0 ? 32'h1 : s[18:17] == 2'h1 ?
          {sk, 2'h3, ez} : s[18:17] == 2'h2 ? {24'h0, ea} : 32'h0);
      end
    end
    summarize();
  end
endmodule
`default_nettype wire
